// file: osq_status_query.sv
// overload status query block: apb registers, event latching and service request line
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module osq_status_query (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  ovl_flags,
  input  wire logic        button_valid,
  input  wire logic [3:0]  button_code,
  input  wire logic [7:0]  comm_err_events,
  output logic             srq_n_o,
  output logic             srq_n_oe,
  output logic             irq,
  output logic             keep_awake,
  output logic             token_reply_mode,
  output logic             echo_console_mode,
  output logic [2:0]       resp_term,
  output logic             pulse_request_mode,
  output logic [15:0]      gain,
  output logic [15:0]      offset,
  output logic [1:0]       bandwidth
);
  osq_pkg::osq_apb_e  ap_state, next_ap_state;
  osq_pkg::osq_srq_e  srq_state, next_srq_state;
  osq_pkg::osq_cfg_s  cfg, next_cfg;
  osq_pkg::osq_qsel_s qsel, next_qsel;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic [15:0] next_gain, next_offset;
  logic [1:0]  next_bw;
  logic [2:0]  overload_event_register, next_ovl_evt, ovl_prev;
  logic [7:0]  overload_enable_mask, next_ovl_mask;
  logic [7:0]  cerr_evt, next_cerr_evt;
  logic [7:0]  comm_error_enable_mask, next_cerr_mask;
  logic [7:0]  sre, next_sre;
  logic [3:0]  last_button_code, next_btn;
  logic [3:0]  irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic        next_irq, req_prev, next_srq_oe;
  logic [7:0]  clr_ovl, next_clr_ovl, clr_cerr, next_clr_cerr;
  logic [3:0]  clr_irq, next_clr_irq;
  logic        clr_btn, next_clr_btn, stb_rel, next_stb_rel;
  logic        acc, wr, timer_start, timer_done, new_req, req_level;
  logic [2:0]  ovl_rise;
  logic [7:0]  status_byte;

  // mask write: whole byte, or one bit picked by index
  function automatic logic [7:0] mask_write(input logic [7:0] old, input logic [31:0] d);
    logic [7:0] m;
    m = old;
    if (d[osq_pkg::MW_SINGLE_BIT]) begin
      m[d[osq_pkg::MW_IDX_LSB +: 3]] = d[0];
    end else begin
      m = d[7:0];
    end
    return m;
  endfunction

  // query view: whole byte, or selected bit in bit 0
  function automatic logic [7:0] sel_bits(input logic [7:0] v, input osq_pkg::osq_qsel_s q);
    return q.en ? {7'h00, v[q.idx]} : v;
  endfunction

  // bits handed back by a query, hence the bits it clears
  function automatic logic [7:0] ret_mask(input osq_pkg::osq_qsel_s q);
    return q.en ? (8'h01 << q.idx) : 8'hFF;
  endfunction

  // bandwidth picked from gain magnitude
  function automatic logic [1:0] bw_for_gain(input logic [15:0] g);
    logic [15:0] a;
    a = g[15] ? 16'(-g) : g;
    if (a <= osq_pkg::BW0_MAX) begin
      return 2'h0;
    end else if (a <= osq_pkg::BW1_MAX) begin
      return 2'h1;
    end else if (a <= osq_pkg::BW2_MAX) begin
      return 2'h2;
    end
    return 2'h3;
  endfunction

  assign acc      = psel && penable && pready;
  assign wr       = acc && pwrite;
  assign ovl_rise = ovl_flags & ~ovl_prev;
  // summary bits and service request level
  assign status_byte = {|(cerr_evt & comm_error_enable_mask), srq_n_oe, 5'h00,
                        |({5'h00, overload_event_register} & overload_enable_mask)};
  assign req_level = |(status_byte & sre & ~(8'h01 << osq_pkg::SB_MSS_BIT));
  assign new_req   = req_level && !req_prev;

  // apb setup phase: decode, fetch read data and note what the access will clear
  always_comb begin
    next_ap_state = osq_pkg::AP_IDLE;
    next_pready   = 1'b0;
    next_pslverr  = 1'b0;
    next_prdata   = prdata;
    next_clr_ovl  = clr_ovl;
    next_clr_cerr = clr_cerr;
    next_clr_btn  = clr_btn;
    next_clr_irq  = clr_irq;
    next_stb_rel  = stb_rel;
    if (ap_state == osq_pkg::AP_IDLE && psel && !penable) begin
      next_ap_state = osq_pkg::AP_ACC;
      next_pready   = 1'b1;
      next_prdata   = 32'h0000_0000;
      next_clr_ovl  = 8'h00;
      next_clr_cerr = 8'h00;
      next_clr_btn  = 1'b0;
      next_clr_irq  = 4'h0;
      next_stb_rel  = 1'b0;
      if (paddr == osq_pkg::A_CTRL) begin
        next_prdata[6:0] = cfg;
      end else if (paddr == osq_pkg::A_GAIN) begin
        next_prdata[15:0] = gain;
      end else if (paddr == osq_pkg::A_OFFSET) begin
        next_prdata[15:0] = offset;
      end else if (paddr == osq_pkg::A_BANDWIDTH) begin
        next_prdata[1:0] = bandwidth;
      end else if (paddr == osq_pkg::A_CMD) begin
        next_prdata = 32'h0000_0000;
      end else if (paddr == osq_pkg::A_QSEL) begin
        next_prdata[3:0] = qsel;
      end else if (paddr == osq_pkg::A_OVL_EVENT) begin
        next_prdata[7:0] = sel_bits({5'h00, overload_event_register}, qsel);
        next_clr_ovl     = pwrite ? 8'h00 : ret_mask(qsel);
      end else if (paddr == osq_pkg::A_OVL_MASK) begin
        next_prdata[7:0] = sel_bits(overload_enable_mask, qsel);
      end else if (paddr == osq_pkg::A_CERR_EVENT) begin
        next_prdata[7:0] = sel_bits(cerr_evt, qsel);
        next_clr_cerr    = pwrite ? 8'h00 : ret_mask(qsel);
      end else if (paddr == osq_pkg::A_CERR_MASK) begin
        next_prdata[7:0] = sel_bits(comm_error_enable_mask, qsel);
      end else if (paddr == osq_pkg::A_SRE) begin
        next_prdata[7:0] = sel_bits(sre, qsel);
      end else if (paddr == osq_pkg::A_STATUS) begin
        next_prdata[7:0] = sel_bits(status_byte, qsel);
        next_stb_rel     = !pwrite && !qsel.en;
      end else if (paddr == osq_pkg::A_LIVE_OVL) begin
        next_prdata[2:0] = ovl_flags;
      end else if (paddr == osq_pkg::A_LAST_BTN) begin
        next_prdata[3:0] = last_button_code;
        next_clr_btn     = !pwrite;
      end else if (paddr == osq_pkg::A_IRQ_STAT) begin
        next_prdata[3:0] = irq_stat;
        next_clr_irq     = pwrite ? 4'h0 : 4'hF;
      end else if (paddr == osq_pkg::A_IRQ_MASK) begin
        next_prdata[3:0] = irq_mask;
      end else begin
        next_pslverr = 1'b1; // unmapped address
      end
    end
  end

  // configuration and mask registers, written at the end of an access
  always_comb begin
    next_cfg       = cfg;
    next_gain      = gain;
    next_offset    = offset;
    next_bw        = bandwidth;
    next_qsel      = qsel;
    next_ovl_mask  = overload_enable_mask;
    next_cerr_mask = comm_error_enable_mask;
    next_sre       = sre;
    next_irq_mask  = irq_mask;
    if (wr && !pslverr) begin
      if (paddr == osq_pkg::A_CTRL) begin
        next_cfg = pwdata[6:0];
      end else if (paddr == osq_pkg::A_GAIN) begin
        next_gain = pwdata[15:0];
        next_bw   = bw_for_gain(pwdata[15:0]);
      end else if (paddr == osq_pkg::A_OFFSET) begin
        next_offset = pwdata[15:0];
      end else if (paddr == osq_pkg::A_BANDWIDTH) begin
        next_bw = pwdata[1:0];
      end else if (paddr == osq_pkg::A_CMD && pwdata[osq_pkg::CMD_RST_BIT]) begin
        next_cfg.keep_awake = 1'b0;
        next_cfg.token      = 1'b0;
        next_gain           = osq_pkg::GAIN_RST;
        next_offset         = osq_pkg::OFFSET_RST;
        next_bw             = osq_pkg::BW_RST;
      end else if (paddr == osq_pkg::A_QSEL) begin
        next_qsel = pwdata[3:0];
      end else if (paddr == osq_pkg::A_OVL_MASK) begin
        next_ovl_mask = mask_write(overload_enable_mask, pwdata);
      end else if (paddr == osq_pkg::A_CERR_MASK) begin
        next_cerr_mask = mask_write(comm_error_enable_mask, pwdata);
      end else if (paddr == osq_pkg::A_SRE) begin
        next_sre = mask_write(sre, pwdata);
      end else if (paddr == osq_pkg::A_IRQ_MASK) begin
        next_irq_mask = pwdata[3:0];
      end
    end
  end

  // sticky event registers: a new event wins over a clear in the same cycle
  always_comb begin
    logic cls;
    cls           = wr && paddr == osq_pkg::A_CMD && pwdata[osq_pkg::CMD_CLS_BIT];
    next_ovl_evt  = overload_event_register;
    next_cerr_evt = cerr_evt;
    next_btn      = last_button_code;
    next_irq_stat = irq_stat;
    if (acc) begin
      next_ovl_evt  = next_ovl_evt & ~clr_ovl[2:0];
      next_cerr_evt = next_cerr_evt & ~clr_cerr;
      next_irq_stat = next_irq_stat & ~clr_irq;
      if (clr_btn) begin
        next_btn = 4'h0;
      end
    end
    if (cls) begin
      next_ovl_evt  = 3'h0;
      next_cerr_evt = 8'h00;
    end
    next_ovl_evt  = next_ovl_evt | ovl_rise;
    next_cerr_evt = next_cerr_evt | comm_err_events;
    if (button_valid) begin
      next_btn = button_code;
    end
    next_irq_stat[osq_pkg::IRQ_OVL_BIT]  = next_irq_stat[osq_pkg::IRQ_OVL_BIT] | (|ovl_rise);
    next_irq_stat[osq_pkg::IRQ_BTN_BIT]  = next_irq_stat[osq_pkg::IRQ_BTN_BIT] | button_valid;
    next_irq_stat[osq_pkg::IRQ_CERR_BIT] = next_irq_stat[osq_pkg::IRQ_CERR_BIT]
                                           | (|comm_err_events);
    next_irq_stat[osq_pkg::IRQ_SRQ_BIT]  = next_irq_stat[osq_pkg::IRQ_SRQ_BIT] | new_req;
    next_irq = |(irq_stat & irq_mask);
  end

  // service request line: latched until a full status query, or a timed pulse
  always_comb begin
    next_srq_state = srq_state;
    timer_start    = 1'b0;
    case (srq_state)
      osq_pkg::SR_IDLE: begin
        if (new_req && cfg.pulse_mode) begin
          next_srq_state = osq_pkg::SR_PULSE;
          timer_start    = 1'b1;
        end else if (new_req) begin
          next_srq_state = osq_pkg::SR_LATCH;
        end
      end
      osq_pkg::SR_PULSE: begin
        if (new_req) begin
          timer_start = 1'b1;
        end else if (timer_done) begin
          next_srq_state = osq_pkg::SR_IDLE;
        end
      end
      default: begin
        if (acc && stb_rel) begin
          next_srq_state = osq_pkg::SR_IDLE;
        end
      end
    endcase
    next_srq_oe = next_srq_state != osq_pkg::SR_IDLE;
  end

  osq_pulse_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (timer_start),
    .done    (timer_done)
  );

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ap_state                <= osq_pkg::AP_IDLE;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      prdata                  <= 32'h0000_0000;
      clr_ovl                 <= 8'h00;
      clr_cerr                <= 8'h00;
      clr_btn                 <= 1'b0;
      clr_irq                 <= 4'h0;
      stb_rel                 <= 1'b0;
      cfg                     <= {1'b0, osq_pkg::TERM_RST, 3'h0};
      gain                    <= osq_pkg::GAIN_RST;
      offset                  <= osq_pkg::OFFSET_RST;
      bandwidth               <= osq_pkg::BW_RST;
      qsel                    <= 4'h0;
      overload_event_register <= 3'h0;
      ovl_prev                <= 3'h0;
      overload_enable_mask    <= 8'h00;
      cerr_evt                <= 8'h00;
      comm_error_enable_mask  <= 8'h00;
      sre                     <= 8'h00;
      last_button_code        <= 4'h0;
      irq_stat                <= 4'h0;
      irq_mask                <= 4'h0;
      irq                     <= 1'b0;
      req_prev                <= 1'b0;
      srq_state               <= osq_pkg::SR_IDLE;
      srq_n_oe                <= 1'b0;
      srq_n_o                 <= 1'b0;
    end else begin
      ap_state                <= next_ap_state;
      pready                  <= next_pready;
      pslverr                 <= next_pslverr;
      prdata                  <= next_prdata;
      clr_ovl                 <= next_clr_ovl;
      clr_cerr                <= next_clr_cerr;
      clr_btn                 <= next_clr_btn;
      clr_irq                 <= next_clr_irq;
      stb_rel                 <= next_stb_rel;
      cfg                     <= next_cfg;
      gain                    <= next_gain;
      offset                  <= next_offset;
      bandwidth               <= next_bw;
      qsel                    <= next_qsel;
      overload_event_register <= next_ovl_evt;
      ovl_prev                <= ovl_flags;
      overload_enable_mask    <= next_ovl_mask;
      cerr_evt                <= next_cerr_evt;
      comm_error_enable_mask  <= next_cerr_mask;
      sre                     <= next_sre;
      last_button_code        <= next_btn;
      irq_stat                <= next_irq_stat;
      irq_mask                <= next_irq_mask;
      irq                     <= next_irq;
      req_prev                <= req_level;
      srq_state               <= next_srq_state;
      srq_n_oe                <= next_srq_oe;
      srq_n_o                 <= 1'b0; // line only ever pulled low
    end
  end

  assign keep_awake         = cfg.keep_awake;
  assign token_reply_mode   = cfg.token;
  assign echo_console_mode  = cfg.console;
  assign resp_term          = cfg.resp_term;
  assign pulse_request_mode = cfg.pulse_mode;

  // helper: length of the current low time on the request line
  logic [9:0] hi_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 10'h000;
    end else begin
      hi_cnt <= srq_n_oe ? 10'(hi_cnt + 10'h001) : 10'h000;
    end
  end

  pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(srq_n_oe) && $past(srq_state) == osq_pkg::SR_PULSE
    |-> hi_cnt >= 10'(osq_pkg::PULSE_CYC))
    else $error("request pulse shorter than 1 us");
  latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    srq_state == osq_pkg::SR_LATCH && !(acc && stb_rel) |=> srq_n_oe)
    else $error("latched request released without status query");
  ovl_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && paddr == osq_pkg::A_OVL_EVENT
    |=> (overload_event_register & $past(clr_ovl[2:0]) & ~$past(ovl_rise)) == 3'h0)
    else $error("returned overload bits not cleared");
  btn_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && clr_btn && !button_valid |=> last_button_code == 4'h0)
    else $error("button code not cleared by query");
  live_query_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && ap_state == osq_pkg::AP_IDLE && paddr == osq_pkg::A_LIVE_OVL
    |=> prdata[2:0] == $past(ovl_flags))
    else $error("live overload answer wrong");
  rst_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == osq_pkg::A_CMD && pwdata[osq_pkg::CMD_RST_BIT]
    |=> gain == osq_pkg::GAIN_RST && offset == 16'h0000 && !keep_awake && !token_reply_mode)
    else $error("reset command defaults wrong");
  rst_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == osq_pkg::A_CMD
    |=> $stable(pulse_request_mode) && $stable(overload_enable_mask) && $stable(sre)
        && $stable(comm_error_enable_mask) && $stable(echo_console_mode)
        && $stable(resp_term))
    else $error("reset command changed kept settings");
  event_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    ovl_flags == ovl_prev && !$rose(overload_event_register[0]) ##1 ovl_flags == ovl_prev
    |-> !$rose(overload_event_register[0]))
    else $error("event bit set without new overload edge");
  cerr_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == osq_pkg::A_CERR_MASK && !pwdata[osq_pkg::MW_SINGLE_BIT]
    |=> comm_error_enable_mask == $past(pwdata[7:0]))
    else $error("comm error mask write lost");
endmodule

// file: osq_pkg.sv
// package: register map, field layout, reset values and timing for the overload status block
package osq_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL       = 8'h00;
  localparam logic [7:0] A_GAIN       = 8'h04;
  localparam logic [7:0] A_OFFSET     = 8'h08;
  localparam logic [7:0] A_BANDWIDTH  = 8'h0C;
  localparam logic [7:0] A_CMD        = 8'h10;
  localparam logic [7:0] A_QSEL       = 8'h14;
  localparam logic [7:0] A_OVL_EVENT  = 8'h18;
  localparam logic [7:0] A_OVL_MASK   = 8'h1C;
  localparam logic [7:0] A_CERR_EVENT = 8'h20;
  localparam logic [7:0] A_CERR_MASK  = 8'h24;
  localparam logic [7:0] A_SRE        = 8'h28;
  localparam logic [7:0] A_STATUS     = 8'h2C;
  localparam logic [7:0] A_LIVE_OVL   = 8'h30;
  localparam logic [7:0] A_LAST_BTN   = 8'h34;
  localparam logic [7:0] A_IRQ_STAT   = 8'h38;
  localparam logic [7:0] A_IRQ_MASK   = 8'h3C;

  // command register bits
  localparam int CMD_RST_BIT = 0;
  localparam int CMD_CLS_BIT = 1;
  // mask write layout: single-bit flag, bit index field, bit value
  localparam int MW_SINGLE_BIT = 8;
  localparam int MW_IDX_LSB    = 16;
  // status byte bit positions
  localparam int SB_OVL_BIT  = 0;
  localparam int SB_MSS_BIT  = 6;
  localparam int SB_CERR_BIT = 7;
  // interrupt status bit positions
  localparam int IRQ_OVL_BIT  = 0;
  localparam int IRQ_BTN_BIT  = 1;
  localparam int IRQ_CERR_BIT = 2;
  localparam int IRQ_SRQ_BIT  = 3;

  // reset values
  localparam logic [15:0] GAIN_RST   = 16'h0064; // +1.00 in hundredths
  localparam logic [15:0] OFFSET_RST = 16'h0000; // 0.000 V in millivolts
  localparam logic [1:0]  BW_RST     = 2'h0;
  localparam logic [2:0]  TERM_RST   = 3'h3;
  // gain magnitude limits (hundredths) for automatic bandwidth
  localparam logic [15:0] BW0_MAX = 16'h00EF; // 2.39
  localparam logic [15:0] BW1_MAX = 16'h01A3; // 4.19
  localparam logic [15:0] BW2_MAX = 16'h03BF; // 9.59

  // service-request pulse timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PULSE_MIN_US  = 1;
  localparam int PULSE_CYC     = (PULSE_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {AP_IDLE = 2'b00, AP_ACC = 2'b01} osq_apb_e;
  typedef enum logic [1:0] {SR_IDLE = 2'b00, SR_PULSE = 2'b01, SR_LATCH = 2'b11} osq_srq_e;

  typedef struct packed {
    logic       pulse_mode;
    logic [2:0] resp_term;
    logic       console;
    logic       token;
    logic       keep_awake;
  } osq_cfg_s;

  typedef struct packed {
    logic       en;
    logic [2:0] idx;
  } osq_qsel_s;
endpackage

// file: osq_pulse_timer.sv
// pulse timer: counts out the minimum low time of a service-request pulse
`timescale 1ns/1ps
module osq_pulse_timer (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      done
);
  logic [8:0] cnt;
  logic [8:0] next_cnt;

  // reload on start, otherwise run down to zero
  always_comb begin
    next_cnt = cnt;
    if (start) begin
      next_cnt = 9'(osq_pkg::PULSE_CYC);
    end else if (cnt != 9'h000) begin
      next_cnt = cnt - 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 9'h000;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign done = (cnt == 9'h001) && !start; // last cycle of the pulse
endmodule

// file: osq_host.sv
// host model: apb master that issues register commands to the status block
`timescale 1ns/1ps
module osq_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer: setup, access held until pready, release, one idle edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// file: testbench.sv
// testbench: register table rows, then events, button codes, service request and irq
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} osq_row_s;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] ovl = 3'h0;
  logic bv = 1'b0;
  logic [3:0] bc = 4'h0;
  logic [7:0] ce = 8'h00;
  logic srq_o, srq_oe, e;
  logic ka, tk, ec, pm;
  logic [2:0] rt;
  logic [1:0] bw;
  logic [15:0] gn, ofs;
  int error_cnt = 0, cmp_count = 0, n;
  osq_row_s rows[20] = '{
    '{1, osq_pkg::A_CERR_MASK, 32'h005A}, '{0, osq_pkg::A_CERR_MASK, 32'h005A},
    '{1, osq_pkg::A_CERR_MASK, 32'h0101}, '{0, osq_pkg::A_CERR_MASK, 32'h005B},
    '{1, osq_pkg::A_OVL_MASK, 32'h0007}, '{1, osq_pkg::A_OVL_MASK, 32'h0001_0100},
    '{0, osq_pkg::A_OVL_MASK, 32'h0005}, '{1, osq_pkg::A_CTRL, 32'h003F},
    '{0, osq_pkg::A_CTRL, 32'h003F}, '{1, osq_pkg::A_GAIN, 32'h0300},
    '{0, osq_pkg::A_BANDWIDTH, 32'h0002}, '{1, osq_pkg::A_CMD, 32'h0001},
    '{0, osq_pkg::A_CTRL, 32'h003C}, '{0, osq_pkg::A_GAIN, 32'h0064},
    '{0, osq_pkg::A_BANDWIDTH, 32'h0000}, '{0, osq_pkg::A_CERR_MASK, 32'h005B},
    '{0, osq_pkg::A_OVL_MASK, 32'h0005}, '{1, osq_pkg::A_QSEL, 32'h000A},
    '{0, osq_pkg::A_OVL_MASK, 32'h0001}, '{1, osq_pkg::A_QSEL, 32'h0000}};
  osq_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  osq_status_query dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ovl_flags(ovl), .button_valid(bv), .button_code(bc),
    .comm_err_events(ce), .srq_n_o(srq_o), .srq_n_oe(srq_oe), .irq(irq), .keep_awake(ka),
    .token_reply_mode(tk), .echo_console_mode(ec), .resp_term(rt), .pulse_request_mode(pm),
    .gain(gn), .offset(ofs), .bandwidth(bw));
  // free-running clock, 4 ns period
  initial forever #2 pclk = ~pclk;
  // compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask
  task automatic btn(input logic [3:0] c);
    bv <= 1'b1;
    bc <= c;
    @(posedge pclk);
    bv <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic flag(input logic [2:0] f);
    ovl <= 3'h0;
    repeat (2) @(posedge pclk);
    ovl <= f;
    repeat (3) @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    #200000;
    error_cnt++;
    finish_test;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rdc(rows[i].a, rows[i].d);
    end
    chk({ofs, gn}, 32'h0000_0064);
    chk({ka, tk, pm, bw}, 32'h0000_0000);
    chk({ec, rt}, 32'h0000_000F);
    $display("register rows done");
    host.xfer(1'b0, 8'h40, 32'h0000_0000, q, e);
    chk({q[30:0], e}, 32'h0000_0001);
    flag(3'h5);
    rdc(osq_pkg::A_LIVE_OVL, 32'h0005);
    rdc(osq_pkg::A_OVL_EVENT, 32'h0005);
    rdc(osq_pkg::A_OVL_EVENT, 32'h0000);
    rdc(osq_pkg::A_LIVE_OVL, 32'h0005);
    flag(3'h6);
    wr(osq_pkg::A_QSEL, 32'h000A);
    rdc(osq_pkg::A_OVL_EVENT, 32'h0001);
    wr(osq_pkg::A_QSEL, 32'h0000);
    rdc(osq_pkg::A_OVL_EVENT, 32'h0002);
    ce <= 8'h08;
    @(posedge pclk);
    ce <= 8'h00;
    repeat (2) @(posedge pclk);
    rdc(osq_pkg::A_CERR_EVENT, 32'h0008);
    $display("overload events done");
    for (int c = 1; c <= 8; c++) begin
      btn(c[3:0]);
      rdc(osq_pkg::A_LAST_BTN, c);
    end
    rdc(osq_pkg::A_LAST_BTN, 32'h0000);
    $display("button codes done");
    wr(osq_pkg::A_SRE, 32'h0001);
    flag(3'h1);
    chk(srq_oe, 32'h0001);
    wr(osq_pkg::A_QSEL, 32'h0008);
    rdc(osq_pkg::A_STATUS, 32'h0001);
    chk(srq_oe, 32'h0001);
    wr(osq_pkg::A_QSEL, 32'h0000);
    host.xfer(1'b0, osq_pkg::A_STATUS, 32'h0000_0000, q, e);
    chk(q, 32'h0000_0041);
    chk(srq_o, 32'h0000);
    chk(srq_oe, 32'h0000);
    rdc(osq_pkg::A_OVL_EVENT, 32'h0001);
    wr(osq_pkg::A_CTRL, 32'h007C);
    wr(osq_pkg::A_CMD, 32'h0001);
    rdc(osq_pkg::A_CTRL, 32'h007C);
    chk(pm, 32'h0001);
    flag(3'h1);
    n = 0;
    while (srq_oe === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 250 && n < 400, 32'h0001);
    $display("service request done");
    rdc(osq_pkg::A_IRQ_STAT, 32'h000F);
    wr(osq_pkg::A_IRQ_MASK, 32'h0000);
    btn(4'h3);
    chk(irq, 32'h0000);
    wr(osq_pkg::A_IRQ_MASK, 32'h0002);
    @(posedge pclk);
    chk(irq, 32'h0001);
    rdc(osq_pkg::A_IRQ_STAT, 32'h0002);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0000);
    $display("interrupt done");
    // power-on reset in mid-run: pulse mode back to off, terminator to its default
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({pm, srq_oe, irq}, 32'h0000);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(osq_pkg::A_CTRL, 32'h0018);
    $display("power-on reset done");
    finish_test;
  end
endmodule
